/* File: hw/ebc_card.sv */
module ebc_card
  import ebc_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite register slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Backplane sense and configuration chain.
  input  wire logic        backplane_type_sense,
  input  wire logic        config_chain_in_n,
  output logic             config_chain_out_n,
  // Arbitration.
  input  wire logic        slot_bus_grant_n,
  input  wire logic        legacy_bus_want_n,
  output logic             slot_bus_request_n,
  // Address phase.
  input  wire logic        read_enable,
  input  wire logic [31:8] multiplexed_upper_address,
  input  wire logic [7:2]  short_low_address,
  input  wire logic [2:0]  address_space_code,
  input  wire logic        compatibility_strobe_n,
  input  wire logic        full_cycle_strobe_n,
  // Data phase.
  input  wire logic        data_output_enable,
  input  wire logic [3:0]  byte_lane_strobes_n,
  input  wire logic        multi_transfer_request_n,
  input  wire logic [31:0] data_in,
  output logic      [31:0] data_out,
  output logic             data_out_en,
  output logic             transfer_acknowledge_n,
  output logic             cache_inhibit_n,
  output logic             multi_transfer_acknowledge_n,
  output logic             slot_slave_response_n
);

  ebc_state_t                state_q;
  logic [EBC_CTRL_W-1:0]     ctrl_q;
  logic [31:0]               hrdata_q;
  logic                      wr_pend_q;
  logic [7:0]                wr_addr_q;
  logic                      legacy_q;
  logic                      legseen_q;
  logic                      configured_q;
  logic [7:0]                base_q;
  logic                      chain_out_n_q;
  logic                      req_n_q;
  logic                      registered_q;
  logic                      gnt_prev_q;
  logic [15:0]               grants_q;
  logic [15:0]               cycles_q;
  logic                      fcs_prev_q;
  logic                      mt_go_q;
  logic                      is_cfg_q;
  logic [31:0]               mem_q [EBC_MEM_WORDS];
  logic [31:0]               dout_q;
  logic                      doe_q;
  logic                      transfer_acknowledge_n_q;
  logic                      cache_inhibit_n_q;
  logic                      multi_transfer_acknowledge_n_q;
  logic                      slave_n_q;
  logic [31:0]               reg_rd_d;
  logic [31:0]               rd_word_d;
  logic [EBC_STAT_W-1:0]     stat_d;
  logic                      ahb_go;
  logic                      want;
  logic                      fcs_fall;
  logic                      space_mem;
  logic                      new_cfg;
  logic                      old_cfg;
  logic                      mem_hit;
  logic                      hit;
  logic                      write_now;
  logic [3:0]                idx;
  logic [7:0]                lane0_now;

  // Outputs come straight from their flops, except the fixed ready and response.
  assign hrdata                       = hrdata_q;
  assign hreadyout                    = 1'b1;
  assign hresp                        = 1'b0;
  assign config_chain_out_n           = chain_out_n_q;
  assign slot_bus_request_n           = req_n_q;
  assign data_out                     = dout_q;
  assign data_out_en                  = doe_q;
  assign transfer_acknowledge_n       = transfer_acknowledge_n_q;
  assign cache_inhibit_n              = cache_inhibit_n_q;
  assign multi_transfer_acknowledge_n = multi_transfer_acknowledge_n_q;
  assign slot_slave_response_n        = slave_n_q;

  // The slave never stalls, so ready and response are fixed OKAY levels.
  // Register decoding happens in the address phase for zero wait states.
  assign ahb_go = hsel & htrans[1] & hready;

  // Status view of the card's own state plus the live legacy bus-want line.
  always_comb begin
    stat_d                   = '0;
    stat_d[EBC_STAT_LEGACY]  = legacy_q;
    stat_d[EBC_STAT_CONFIG]  = configured_q;
    stat_d[EBC_STAT_WANT]    = ~legacy_bus_want_n;
    stat_d[EBC_STAT_REG]     = registered_q;
    stat_d[EBC_STAT_LEGSEEN] = legseen_q;
  end

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    case (haddr[7:0])
      EBC_CTRL_OFS: reg_rd_d = {27'h0, ctrl_q};
      EBC_STAT_OFS: reg_rd_d = {27'h0, stat_d};
      EBC_CNT_OFS:  reg_rd_d = {grants_q, cycles_q};
      EBC_ID_OFS:   reg_rd_d = EBC_CARD_ID;
      EBC_BASE_OFS: reg_rd_d = {24'h0, base_q};
      default:      reg_rd_d = 32'h0;
    endcase
  end

  // Address phase capture; write data lands in the following data phase.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h0;
    end else begin
      wr_pend_q <= ahb_go & hwrite;
      if (ahb_go) begin
        wr_addr_q <= haddr[7:0];
      end
      if (ahb_go && !hwrite) begin
        hrdata_q <= reg_rd_d;
      end
    end
  end

  // Control register written by software steers the card.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= EBC_CTRL_RST;
    end else if (wr_pend_q && wr_addr_q == EBC_CTRL_OFS) begin
      ctrl_q <= hwdata[EBC_CTRL_W-1:0];
    end
  end

  // Legacy-cycle flag is sticky; a new sighting beats a software clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      legseen_q <= 1'b0;
    end else if (!compatibility_strobe_n && full_cycle_strobe_n) begin
      legseen_q <= 1'b1;
    end else if (wr_pend_q && wr_addr_q == EBC_STAT_OFS &&
                 hwdata[EBC_STAT_LEGSEEN]) begin
      legseen_q <= 1'b0;
    end
  end

  // Backplane type and configuration chain.
  always_ff @(posedge clk) begin
    if (rst) begin
      legacy_q      <= 1'b0;
      chain_out_n_q <= 1'b1;
    end else begin
      legacy_q <= ~backplane_type_sense;
      if (legacy_q) begin
        chain_out_n_q <= config_chain_in_n;
      end else begin
        chain_out_n_q <= ~(configured_q | ctrl_q[EBC_CTRL_SHUTUP]);
      end
    end
  end

  // Master registration: the request line changes level once per change of
  // intent. Bus ownership and grant acknowledge have no output here at all.
  assign want = ctrl_q[EBC_CTRL_MASTER] & ~legacy_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      req_n_q      <= 1'b1;
      registered_q <= 1'b0;
      gnt_prev_q   <= 1'b1;
      grants_q     <= 16'h0000;
    end else begin
      gnt_prev_q <= slot_bus_grant_n;
      if (want != registered_q) begin
        req_n_q      <= ~req_n_q;
        registered_q <= want;
      end
      // Each grant stands for one full cycle, so falling edges are counted.
      if (registered_q && gnt_prev_q && !slot_bus_grant_n) begin
        grants_q <= grants_q + 16'h0001;
      end
    end
  end

  // Cycle decode at the falling edge of the full-cycle strobe. The
  // compatibility strobe plays no part, so legacy-only cycles never start.
  assign fcs_fall  = fcs_prev_q & ~full_cycle_strobe_n;
  assign space_mem = (address_space_code == 3'b100) |
                     (address_space_code == 3'b010) |
                     (address_space_code == 3'b101) |
                     (address_space_code == 3'b011);
  assign new_cfg   = ~configured_q & ~config_chain_in_n &
                     (multiplexed_upper_address[31:16] ==
                      EBC_NEW_CFG_BASE);
  assign old_cfg   = ~configured_q & ~config_chain_in_n &
                     ctrl_q[EBC_CTRL_LEGCFG] &
                     (multiplexed_upper_address[31:16] == EBC_OLD_CFG_BASE);
  assign mem_hit   = configured_q &
                     (multiplexed_upper_address[31:24] == base_q);
  assign hit       = ~legacy_q & space_mem & (new_cfg | old_cfg | mem_hit);

  // Upper address is gone soon after the strobe, so it is caught here.
  always_ff @(posedge clk) begin
    if (rst) begin
      fcs_prev_q <= 1'b1;
      is_cfg_q   <= 1'b0;
    end else begin
      fcs_prev_q <= full_cycle_strobe_n;
      if (fcs_fall) begin
        is_cfg_q <= new_cfg | old_cfg;
      end
    end
  end

  // Low address is read live each transfer; it can change between transfers of one cycle.
  assign idx       = short_low_address[5:2];
  assign lane0_now = mem_q[idx][7:0];
  assign write_now = (state_q == ST_RESP) & ~full_cycle_strobe_n &
                     data_output_enable & ~read_enable &
                     (byte_lane_strobes_n != EBC_DS_NONE);

  // Read word; with caching off only the strobed lanes carry data.
  always_comb begin
    rd_word_d = is_cfg_q ? EBC_CARD_ID : mem_q[idx];
    for (int i = 0; i < 4; i++) begin
      if (!cache_inhibit_n_q && byte_lane_strobes_n[i]) begin
        rd_word_d[8*i +: 8] = 8'h00;
      end
    end
  end

  // Local memory takes only the strobed bytes of a write.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int w = 0; w < EBC_MEM_WORDS; w++) begin
        mem_q[w] <= 32'h0;
      end
    end else if (write_now && !is_cfg_q) begin
      for (int i = 0; i < 4; i++) begin
        if (!byte_lane_strobes_n[i]) begin
          mem_q[idx][8*i +: 8] <= data_in[8*i +: 8];
        end
      end
    end
  end

  // A configuration write places the card at its base.
  always_ff @(posedge clk) begin
    if (rst) begin
      configured_q <= 1'b0;
      base_q       <= EBC_BASE_RST;
    end else if (write_now && is_cfg_q && !byte_lane_strobes_n[3]) begin
      configured_q <= 1'b1;
      base_q       <= data_in[31:24];
    end
  end

  // Count cycles this card answered.
  always_ff @(posedge clk) begin
    if (rst) begin
      cycles_q <= 16'h0000;
    end else if (state_q == ST_IDLE && fcs_fall && hit) begin
      cycles_q <= cycles_q + 16'h0001;
    end
  end

  // Slave cycle engine. Response and qualifiers go out one edge after the
  // strobe; the whole cycle is dropped the moment the strobe rises.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      slave_n_q <= 1'b1;
      cache_inhibit_n_q  <= 1'b1;
      multi_transfer_acknowledge_n_q <= 1'b1;
      transfer_acknowledge_n_q <= 1'b1;
      dout_q    <= 32'h0;
      doe_q     <= 1'b0;
      mt_go_q   <= 1'b0;
    end else if (full_cycle_strobe_n && state_q != ST_IDLE) begin
      state_q   <= ST_IDLE;
      slave_n_q <= 1'b1;
      cache_inhibit_n_q  <= 1'b1;
      multi_transfer_acknowledge_n_q <= 1'b1;
      transfer_acknowledge_n_q <= 1'b1;
      doe_q     <= 1'b0;
      mt_go_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (fcs_fall && hit) begin
            state_q   <= ST_RESP;
            slave_n_q <= 1'b0;
            cache_inhibit_n_q  <= ~(new_cfg | old_cfg |
                           ~ctrl_q[EBC_CTRL_CACHE]);
            multi_transfer_acknowledge_n_q <= ~(ctrl_q[EBC_CTRL_MULTI] &
                           ~(new_cfg | old_cfg));
          end
        end
        ST_RESP: begin
          // A master that wants bursts asks at the start of data time.
          if (!multi_transfer_request_n && !multi_transfer_acknowledge_n_q) begin
            mt_go_q <= 1'b1;
          end
          if (data_output_enable && read_enable) begin
            dout_q  <= rd_word_d;
            doe_q   <= 1'b1;
            state_q <= ST_READ;
          end else if (write_now) begin
            transfer_acknowledge_n_q <= 1'b0;
            state_q   <= ST_ACK;
          end
        end
        ST_READ: begin
          // Data has stood a full cycle before it is acknowledged.
          transfer_acknowledge_n_q <= 1'b0;
          state_q   <= ST_ACK;
        end
        ST_ACK: begin
          // Without the handshake the acknowledge stands until the strobe
          // rises, so a plain master never sees it vanish early.
          if (mt_go_q && multi_transfer_request_n) begin
            transfer_acknowledge_n_q <= 1'b1;
            doe_q     <= 1'b0;
            state_q   <= ST_MTWAIT;
          end
        end
        ST_MTWAIT: begin
          if (!multi_transfer_request_n) begin
            state_q <= ST_RESP;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_acked_multi;
    !transfer_acknowledge_n && !multi_transfer_acknowledge_n && mt_go_q;
  endsequence

  sequence s_mt_release;
    multi_transfer_request_n && !full_cycle_strobe_n;
  endsequence

  chain_pass_a: assert property (
    legacy_q |=> config_chain_out_n == $past(config_chain_in_n))
    else $error("chain not passed through on legacy backplane");

  req_toggle_a: assert property (
    $changed(slot_bus_request_n) == $changed(registered_q))
    else $error("request line toggled without a registration change");

  space_reserved_a: assert property (
    (fcs_fall && state_q == ST_IDLE &&
     (address_space_code == 3'b000 || address_space_code == 3'b110 ||
      address_space_code == 3'b001 || address_space_code == 3'b111))
    |=> slot_slave_response_n)
    else $error("response to a non-memory space");

  legacy_ignore_a: assert property (
    (!compatibility_strobe_n && full_cycle_strobe_n && state_q == ST_IDLE)
    |=> slot_slave_response_n [*2])
    else $error("response to a legacy-only cycle");

  quick_resp_a: assert property (
    (fcs_fall && hit && state_q == ST_IDLE) |=> !slot_slave_response_n)
    else $error("slave response late");

  doe_gate_a: assert property (
    $rose(data_out_en) |-> $past(data_output_enable) && $past(read_enable))
    else $error("data driven before output enable");

  read_setup_a: assert property (
    ($fell(transfer_acknowledge_n) && data_out_en) |-> $past(data_out_en))
    else $error("read acknowledged without prior data");

  cfg_qual_a: assert property (
    ($fell(slot_slave_response_n) && is_cfg_q)
    |-> !cache_inhibit_n && multi_transfer_acknowledge_n)
    else $error("config cycle qualifiers wrong");

  cache_qual_a: assert property (
    ($fell(slot_slave_response_n) && !is_cfg_q)
    |-> cache_inhibit_n == $past(ctrl_q[EBC_CTRL_CACHE]))
    else $error("cache inhibit does not follow caching mode");

  lane_keep_a: assert property (
    (write_now && !is_cfg_q && byte_lane_strobes_n[0])
    |=> mem_q[$past(idx)][7:0] == $past(lane0_now))
    else $error("unstrobed byte lane overwritten");

  mt_release_a: assert property (
    s_acked_multi ##0 s_mt_release |=> transfer_acknowledge_n)
    else $error("acknowledge held after multi-transfer release");

  ack_hold_a: assert property (
    (!transfer_acknowledge_n && !mt_go_q && !full_cycle_strobe_n)
    |=> !transfer_acknowledge_n)
    else $error("acknowledge dropped while the cycle still runs");

  cycle_end_a: assert property (
    (full_cycle_strobe_n && state_q != ST_IDLE)
    |=> transfer_acknowledge_n && slot_slave_response_n && !data_out_en)
    else $error("outputs not released at end of cycle");

endmodule : ebc_card

/* File: hw/ebc_pkg.sv */
package ebc_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0]  EBC_CTRL_OFS     = 8'h00;
  localparam logic [7:0]  EBC_STAT_OFS     = 8'h04;
  localparam logic [7:0]  EBC_CNT_OFS      = 8'h08;
  localparam logic [7:0]  EBC_ID_OFS       = 8'h0c;
  localparam logic [7:0]  EBC_BASE_OFS     = 8'h10;

  // Control register fields.
  localparam int          EBC_CTRL_W       = 5;
  localparam int          EBC_CTRL_MASTER  = 0;
  localparam int          EBC_CTRL_CACHE   = 1;
  localparam int          EBC_CTRL_MULTI   = 2;
  localparam int          EBC_CTRL_LEGCFG  = 3;
  localparam int          EBC_CTRL_SHUTUP  = 4;
  localparam logic [4:0]  EBC_CTRL_RST     = 5'h00;

  // Status register fields.
  localparam int          EBC_STAT_W       = 5;
  localparam int          EBC_STAT_LEGACY  = 0;
  localparam int          EBC_STAT_CONFIG  = 1;
  localparam int          EBC_STAT_WANT    = 2;
  localparam int          EBC_STAT_REG     = 3;
  localparam int          EBC_STAT_LEGSEEN = 4;

  // Configuration bases, upper sixteen address bits.
  localparam logic [15:0] EBC_NEW_CFG_BASE = 16'hff00;
  localparam logic [15:0] EBC_OLD_CFG_BASE = 16'h00e8;

  // Card identity word; the value is arbitrary.
  localparam logic [31:0] EBC_CARD_ID      = 32'h5a5a0001;

  // Local memory and misc reset values.
  localparam int          EBC_MEM_WORDS    = 16;
  localparam logic [7:0]  EBC_BASE_RST     = 8'h00;
  localparam logic [3:0]  EBC_DS_NONE      = 4'hf;

  // Slave cycle states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RESP,
    ST_READ,
    ST_ACK,
    ST_MTWAIT
  } ebc_state_t;

endpackage : ebc_pkg

/* File: tb/ebc_master.sv */
module ebc_master (
  // Clock.
  input  wire logic        clk,
  // Cycle signals driven by the master.
  output logic             read_enable,
  output logic      [31:8] multiplexed_upper_address,
  output logic      [7:2]  short_low_address,
  output logic      [2:0]  address_space_code,
  output logic             compatibility_strobe_n,
  output logic             full_cycle_strobe_n,
  output logic             data_output_enable,
  output logic      [3:0]  byte_lane_strobes_n,
  output logic             multi_transfer_request_n,
  output logic      [31:0] data_in,
  // Controller arbitration lines.
  output logic             slot_bus_grant_n,
  output logic             legacy_bus_want_n,
  // Slave answers.
  input  wire logic [31:0] data_out,
  input  wire logic        data_out_en,
  input  wire logic        transfer_acknowledge_n,
  input  wire logic        cache_inhibit_n,
  input  wire logic        multi_transfer_acknowledge_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus; this master asks for multiple transfers only in the pair task.
  initial begin
    {read_enable, data_output_enable} = 2'h2;
    {multiplexed_upper_address, short_low_address} = 30'h0;
    {address_space_code, byte_lane_strobes_n} = 7'h0f;
    data_in = 32'h0;
    {compatibility_strobe_n, full_cycle_strobe_n} = 2'h3;
    {multi_transfer_request_n, slot_bus_grant_n} = 2'h3;
    legacy_bus_want_n = 1'b1;
  end

  // One full cycle; waits a bounded time for the acknowledge.
  task automatic cycle(input logic rd, input logic [31:0] a,
                       input logic [2:0] fc, input logic [3:0] ds,
                       input logic [31:0] wd, output logic [31:0] q,
                       output logic hit, output logic [1:0] fl);
    int i;
    @(posedge clk);
    read_enable <= rd;
    multiplexed_upper_address <= a[31:8];
    short_low_address <= a[7:2];
    address_space_code <= fc;
    @(posedge clk);
    full_cycle_strobe_n <= 1'b0;
    @(posedge clk);
    // The upper lines float once the strobe is seen, so show junk.
    multiplexed_upper_address <= ~a[31:8];
    data_output_enable <= 1'b1;
    byte_lane_strobes_n <= ds;
    data_in <= rd ? ~wd : wd;
    hit = 1'b0;
    for (i = 0; i < 16 && !hit; i++) begin
      @(posedge clk);
      hit = (transfer_acknowledge_n === 1'b0);
    end
    q = data_out_en ? data_out : 32'hx;
    fl = {cache_inhibit_n, multi_transfer_acknowledge_n};
    {full_cycle_strobe_n, data_output_enable} <= 2'h2;
    byte_lane_strobes_n <= 4'hf;
    data_in <= ~wd;
    repeat (2) @(posedge clk);
  endtask : cycle

  // Waits a bounded time for the acknowledge to reach level v.
  task automatic wait_ack(input logic v);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      if (transfer_acknowledge_n === v) break;
    end
  endtask : wait_ack

  // Two short reads inside one full cycle through the burst handshake.
  task automatic pair(input logic [31:0] a, input logic [7:2] b,
                      output logic [31:0] q0, q1);
    @(posedge clk);
    read_enable <= 1'b1;
    multiplexed_upper_address <= a[31:8];
    short_low_address <= a[7:2];
    address_space_code <= 3'h4;
    @(posedge clk);
    full_cycle_strobe_n <= 1'b0;
    @(posedge clk);
    multiplexed_upper_address <= ~a[31:8];
    {data_output_enable, multi_transfer_request_n} <= 2'h2;
    byte_lane_strobes_n <= 4'h0;
    wait_ack(1'b0);
    q0 = data_out;
    multi_transfer_request_n <= 1'b1;
    short_low_address <= b;
    wait_ack(1'b1);
    multi_transfer_request_n <= 1'b0;
    wait_ack(1'b0);
    q1 = data_out;
    {full_cycle_strobe_n, data_output_enable} <= 2'h2;
    {multi_transfer_request_n, byte_lane_strobes_n} <= 5'h1f;
    repeat (2) @(posedge clk);
  endtask : pair

  // One grant pulse to the single registered card.
  task automatic grant();
    @(posedge clk);
    slot_bus_grant_n <= 1'b0;
    @(posedge clk);
    slot_bus_grant_n <= 1'b1;
  endtask : grant

  // Pending legacy request shown on the bus-want line.
  task automatic want(input logic v);
    @(posedge clk);
    legacy_bus_want_n <= ~v;
  endtask : want

  // A legacy card-as-master cycle: compatibility strobe alone.
  task automatic legacy_probe();
    @(posedge clk);
    compatibility_strobe_n <= 1'b0;
    repeat (4) @(posedge clk);
    compatibility_strobe_n <= 1'b1;
  endtask : legacy_probe
endmodule : ebc_master

/* File: tb/testbench.sv */
module testbench import ebc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // Bench-driven inputs start at defined levels.
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, data_in, data_out;
  logic        hready, hreadyout, hresp, config_chain_out_n;
  logic        backplane_type_sense = 1'b1, config_chain_in_n = 1'b0;
  logic        slot_bus_request_n, slot_bus_grant_n, legacy_bus_want_n;
  logic        read_enable, compatibility_strobe_n, full_cycle_strobe_n;
  logic [31:8] multiplexed_upper_address;
  logic [7:2]  short_low_address;
  logic [2:0]  address_space_code;
  logic [3:0]  byte_lane_strobes_n;
  logic        data_output_enable, multi_transfer_request_n, data_out_en;
  logic        transfer_acknowledge_n, cache_inhibit_n;
  logic        multi_transfer_acknowledge_n, slot_slave_response_n;
  int          n_errors = 0, num_checks = 0;
  logic [31:0] r, r2;
  logic        h;
  logic [1:0]  f;

  // The only slave's ready is the bus ready.
  assign hready = hreadyout;

  // Clock at 20 MHz.
  always #25 clk = ~clk;

  ebc_card dut_u (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .backplane_type_sense,
    .config_chain_in_n, .config_chain_out_n, .slot_bus_grant_n,
    .legacy_bus_want_n, .slot_bus_request_n, .read_enable,
    .multiplexed_upper_address, .short_low_address, .address_space_code,
    .compatibility_strobe_n, .full_cycle_strobe_n, .data_output_enable,
    .byte_lane_strobes_n, .multi_transfer_request_n, .data_in, .data_out,
    .data_out_en, .transfer_acknowledge_n, .cache_inhibit_n,
    .multi_transfer_acknowledge_n, .slot_slave_response_n);

  ebc_master mst_u (.clk, .read_enable, .multiplexed_upper_address,
    .short_low_address, .address_space_code, .compatibility_strobe_n,
    .full_cycle_strobe_n, .data_output_enable, .byte_lane_strobes_n,
    .multi_transfer_request_n, .data_in, .slot_bus_grant_n,
    .legacy_bus_want_n, .data_out, .data_out_en, .transfer_acknowledge_n,
    .cache_inhibit_n, .multi_transfer_acknowledge_n);

  task automatic check(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Single AHB-Lite word transfer; the data phase waits on ready too.
  task automatic ahb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    @(posedge clk);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, a};
    do @(posedge clk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : ahb

  task automatic t_reset();
    @(posedge clk);
    check({config_chain_out_n, slot_bus_request_n, transfer_acknowledge_n,
           cache_inhibit_n, multi_transfer_acknowledge_n,
           slot_slave_response_n, data_out_en, hresp, hreadyout}, 9'h1f9);
    ahb(1'b0, EBC_CTRL_OFS, 32'h0, r);
    check(r[4:0], EBC_CTRL_RST);
    ahb(1'b0, EBC_ID_OFS, 32'h0, r);
    check(r, EBC_CARD_ID);
    ahb(1'b0, 32'h20, 32'h0, r);
    check(r, 32'h0);
    $display("reset test done");
  endtask : t_reset

  // Configuration reads at both bases and a write at the new base, after refused space codes.
  task automatic t_config();
    logic [2:0] bad [4] = '{3'h0, 3'h6, 3'h1, 3'h7};
    foreach (bad[i]) begin
      mst_u.cycle(1'b1, 32'hff000000, bad[i], 4'h0, 32'h0, r, h, f);
      check(h, 1'b0);
    end
    mst_u.cycle(1'b1, 32'h00e80000, 3'h4, 4'h0, 32'h0, r, h, f);
    check(h, 1'b0);
    ahb(1'b1, EBC_CTRL_OFS, 32'hc, r);
    mst_u.cycle(1'b1, 32'h00e80000, 3'h4, 4'h3, 32'h0, r, h, f);
    check(r, {EBC_CARD_ID[31:16], 16'h0});
    check(f, 2'h1);
    ahb(1'b1, EBC_CTRL_OFS, 32'h0, r);
    mst_u.cycle(1'b1, 32'hff000000, 3'h4, 4'h0, 32'h0, r, h, f);
    check(r, EBC_CARD_ID);
    check(f, 2'h1);
    mst_u.cycle(1'b0, 32'hff000000, 3'h4, 4'h0, 32'h40000000, r, h, f);
    check(h, 1'b1);
    check(config_chain_out_n, 1'b0);
    ahb(1'b0, EBC_BASE_OFS, 32'h0, r);
    check(r[7:0], 8'h40);
    $display("config test done");
  endtask : t_config

  // Byte lanes, caching and multi-transfer answer on local memory.
  task automatic t_mem();
    mst_u.cycle(1'b0, 32'h4000000c, 3'h4, 4'h0, 32'h11223344, r, h, f);
    mst_u.cycle(1'b0, 32'h4000000c, 3'h4, 4'h3, 32'haabbccdd, r, h, f);
    mst_u.cycle(1'b1, 32'h4000000c, 3'h2, 4'h0, 32'h0, r, h, f);
    check(r, 32'haabb3344);
    mst_u.cycle(1'b1, 32'h4000000c, 3'h2, 4'h3, 32'h0, r, h, f);
    check(r, 32'haabb0000);
    check(f, 2'h1);
    ahb(1'b1, EBC_CTRL_OFS, 32'h2, r);
    mst_u.cycle(1'b1, 32'h4000000c, 3'h5, 4'h3, 32'h0, r, h, f);
    check(r, 32'haabb3344);
    check(f, 2'h3);
    ahb(1'b1, EBC_CTRL_OFS, 32'h6, r);
    mst_u.cycle(1'b1, 32'h4000000c, 3'h3, 4'h0, 32'h0, r, h, f);
    check(f, 2'h2);
    mst_u.pair(32'h40000010, 6'h03, r, r2);
    check(r, 32'h0);
    check(r2, 32'haabb3344);
    $display("memory test done");
  endtask : t_mem

  task automatic t_compat();
    mst_u.legacy_probe();
    check(slot_slave_response_n, 1'b1);
    ahb(1'b0, EBC_STAT_OFS, 32'h0, r);
    check(r[EBC_STAT_LEGSEEN], 1'b1);
    ahb(1'b1, EBC_STAT_OFS, 32'h10, r);
    ahb(1'b0, EBC_STAT_OFS, 32'h0, r);
    check(r[EBC_STAT_LEGSEEN], 1'b0);
    $display("compat test done");
  endtask : t_compat

  // Registration toggles, grants counted, legacy want shown.
  task automatic t_arb();
    ahb(1'b1, EBC_CTRL_OFS, 32'h1, r);
    repeat (3) @(posedge clk);
    check(slot_bus_request_n, 1'b0);
    mst_u.grant();
    mst_u.grant();
    mst_u.want(1'b1);
    ahb(1'b0, EBC_STAT_OFS, 32'h0, r);
    check({r[EBC_STAT_REG], r[EBC_STAT_WANT]}, 2'h3);
    ahb(1'b0, EBC_CNT_OFS, 32'h0, r);
    check(r, {16'h2, 16'ha});
    ahb(1'b1, EBC_CTRL_OFS, 32'h0, r);
    repeat (3) @(posedge clk);
    check(slot_bus_request_n, 1'b1);
    $display("arbitration test done");
  endtask : t_arb

  // Legacy backplane: silent card, chain passed straight through.
  task automatic t_old_bp();
    @(posedge clk);
    backplane_type_sense <= 1'b0;
    config_chain_in_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(config_chain_out_n, 1'b1);
    config_chain_in_n <= 1'b0;
    repeat (3) @(posedge clk);
    check(config_chain_out_n, 1'b0);
    mst_u.cycle(1'b1, 32'h4000000c, 3'h4, 4'h0, 32'h0, r, h, f);
    check(h, 1'b0);
    $display("old backplane test done");
  endtask : t_old_bp

  // Main sequence after the reset span.
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_config();
    t_mem();
    t_compat();
    t_arb();
    t_old_bp();
    close_out();
  end

  // Watchdog: far beyond the few hundred cycles the tests need.
  initial begin
    #2000000;
    n_errors++;
    close_out();
  end
endmodule : testbench
